// [rtl/sop_clk_div.sv]
// Serial clock generator: one high cycle every divisor+1 reference cycles
`timescale 1ns/1ps
module sop_clk_div
  import sop_pkg::*;
(
  input wire logic ref_clk, // Reference clock
  input wire logic sys_rst, // Synchronous reset, high
  input wire logic run, // Generate the clock
  input wire logic [1:0] divisor, // Divisor, 1 to 3
  output logic sclk // Generated serial clock
);
  import sop_pkg::*;

  typedef struct packed {
    logic [1:0] cnt;
    logic sclk;
  } sop_div_state_t;

  sop_div_state_t s_reg;
  sop_div_state_t s_next;

  always_comb begin
    s_next = s_reg;
    if (!run) begin
      s_next.cnt = 2'h0;
    end else if (s_reg.cnt >= divisor) begin
      s_next.cnt = 2'h0;
    end else begin
      s_next.cnt = s_reg.cnt + 2'h1;
    end
    s_next.sclk = run && (s_next.cnt == 2'h0);
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sclk = s_reg.sclk;
endmodule // sop_clk_div

// [rtl/sop_dsp.sv]
// Controller end: drives clock and sync for a slave port and collects frames
`timescale 1ns/1ps
module sop_dsp
  import sop_pkg::*;
(
  input wire logic ref_clk, // Reference clock, 10 MHz
  input wire logic sys_rst, // Synchronous reset, high
  sop_link_if.host link, // Serial link
  input wire logic [SOP_H_ADDR_W-1:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [3:0] avs_byteenable, // Byte lanes
  input wire logic [31:0] avs_writedata, // Write data
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest // Stall
);
  import sop_pkg::*;

  typedef struct packed {
    logic [5:0] ctrl;
    logic done;
    logic [SOP_SAMPLE_W-1:0] rxI;
    logic [SOP_SAMPLE_W-1:0] rxQ;
    logic [SOP_FRAME_W-1:0] rxShift;
    logic [5:0] rxLeft;
    logic rxActive;
    logic sclkPrev;
    logic fsyncOut;
    logic ack;
    logic [31:0] rdata;
  } sop_dsp_state_t;

  sop_dsp_state_t s_reg;
  sop_dsp_state_t s_next;
  logic genSclk;
  logic rise;
  logic [1:0] wordLen;
  logic [SOP_FRAME_W-1:0] rxWord;

  assign wordLen = s_reg.ctrl[SOP_HC_WL_MSB:SOP_HC_WL_LSB];
  assign rise = link.sclk && !s_reg.sclkPrev;
  assign rxWord = {s_reg.rxShift[SOP_FRAME_W-2:0], link.serialOut};

  sop_clk_div u_clk_div (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .run(s_reg.ctrl[SOP_HC_CLK]),
    .divisor(sop_clamp_div({2'h0, s_reg.ctrl[SOP_HC_DIV_MSB:SOP_HC_DIV_LSB]})),
    .sclk(genSclk)
  ); // R01 R13 R14

  always_comb begin
    s_next = s_reg;
    s_next.sclkPrev = link.sclk;
    if (rise) begin
      if (s_reg.rxActive) begin
        s_next.rxShift = rxWord;
        s_next.rxLeft = s_reg.rxLeft - 6'h01;
        if (s_reg.rxLeft == 6'h01) begin
          s_next.rxActive = 1'b0;
          s_next.done = 1'b1;
          if (wordLen == SOP_WL_12) begin
            s_next.rxI = {rxWord[23:12], 12'h000};
            s_next.rxQ = {rxWord[11:0], 12'h000};
          end else if (wordLen == SOP_WL_16) begin
            s_next.rxI = {rxWord[31:16], 8'h00};
            s_next.rxQ = {rxWord[15:0], 8'h00};
          end else begin
            s_next.rxI = rxWord[47:24];
            s_next.rxQ = rxWord[23:0];
          end
        end
      end else if (link.frameSync) begin
        s_next.rxActive = 1'b1;
        s_next.rxLeft = sop_frame_bits(wordLen);
        s_next.fsyncOut = 1'b0;
      end else if (s_reg.ctrl[SOP_HC_CLK] && s_reg.ctrl[SOP_HC_AUTO] && link.dataReady) begin
        s_next.fsyncOut = 1'b1; // R03
      end
    end

    s_next.ack = (avs_read || avs_write) && !s_reg.ack;
    if (avs_read && !s_reg.ack) begin
      s_next.rdata = 32'h00000000;
      unique case (avs_address)
        SOP_H_CTRL_ADDR: s_next.rdata[5:0] = s_reg.ctrl;
        SOP_H_STAT_ADDR: begin
          s_next.rdata[SOP_HS_DONE] = s_reg.done;
          s_next.rdata[SOP_HS_READY] = link.dataReady;
        end
        SOP_H_RXI_ADDR: s_next.rdata[23:0] = s_reg.rxI;
        SOP_H_RXQ_ADDR: s_next.rdata[23:0] = s_reg.rxQ;
        default: s_next.rdata = 32'h00000000;
      endcase
    end
    if (avs_write && s_reg.ack && avs_byteenable[0]) begin
      if (avs_address == SOP_H_CTRL_ADDR) begin
        s_next.ctrl = avs_writedata[5:0];
      end
      // Write one clears; a frame finishing now keeps it set
      if (avs_address == SOP_H_STAT_ADDR && avs_writedata[SOP_HS_DONE]
          && !(rise && s_reg.rxActive && s_reg.rxLeft == 6'h01)) begin
        s_next.done = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s_reg <= '0;
      s_reg.ctrl <= SOP_H_CTRL_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign link.sclkHost = genSclk;
  assign link.sclkHostOen = !s_reg.ctrl[SOP_HC_CLK]; // R01
  assign link.fsyncHost = s_reg.fsyncOut;
  assign link.fsyncHostOen = !s_reg.ctrl[SOP_HC_CLK]; // R01
  assign avs_readdata = s_reg.rdata;
  assign avs_waitrequest = (avs_read || avs_write) && !s_reg.ack;
endmodule // sop_dsp

// [rtl/sop_link_if.sv]
// Serial link between the output port and its controller, with wire resolution
`timescale 1ns/1ps
interface sop_link_if;
  logic sclkDev;
  logic sclkDevOen;
  logic sclkHost;
  logic sclkHostOen;
  logic fsyncDev;
  logic fsyncDevOen;
  logic fsyncHost;
  logic fsyncHostOen;
  logic serialOutDev;
  logic serialOutOen;
  logic frameEnd;
  logic dataReady;
  logic sclk;
  logic frameSync;
  logic serialOut;

  // Undriven lines read low
  assign sclk = !sclkDevOen ? sclkDev : (!sclkHostOen ? sclkHost : 1'b0);
  assign frameSync = !fsyncDevOen ? fsyncDev : (!fsyncHostOen ? fsyncHost : 1'b0);
  assign serialOut = !serialOutOen ? serialOutDev : 1'b0;

  modport device (
    output sclkDev, sclkDevOen, fsyncDev, fsyncDevOen,
    output serialOutDev, serialOutOen, frameEnd, dataReady,
    input sclk, frameSync, serialOut
  );
  modport host (
    output sclkHost, sclkHostOen, fsyncHost, fsyncHostOen,
    input sclk, frameSync, serialOut, frameEnd, dataReady
  );
endinterface

// [rtl/sop_pkg.sv]
// Shared constants, types and helpers for the serial output port and its controller
package sop_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Device register map (index = printed offset, byte address = 4 x index)
  localparam int SOP_ADDR_W = 12;
  localparam logic [SOP_ADDR_W-1:0] SOP_CTRL_IDX = 12'h0A9;
  localparam logic [SOP_ADDR_W-1:0] SOP_STAT_IDX = 12'h0AA;
  localparam logic [SOP_ADDR_W-1:0] SOP_CTRL_ADDR = {SOP_CTRL_IDX[9:0], 2'b00};
  localparam logic [SOP_ADDR_W-1:0] SOP_STAT_ADDR = {SOP_STAT_IDX[9:0], 2'b00};

  // Control register fields
  localparam int SOP_CTRL_W = 10;
  localparam logic [SOP_CTRL_W-1:0] SOP_CTRL_RST = 10'h000;
  localparam int SOP_DIV_LSB = 0;
  localparam int SOP_DIV_MSB = 3;
  localparam int SOP_MASTER_BIT = 4;
  localparam int SOP_WL_LSB = 5;
  localparam int SOP_WL_MSB = 6;
  localparam int SOP_FS_LSB = 7;
  localparam int SOP_FS_MSB = 8;
  localparam int SOP_MAP_BIT = 9;

  // Status register fields
  localparam int SOP_ST_READY = 0;
  localparam int SOP_ST_BUSY = 1;
  localparam int SOP_ST_MASTER = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Word lengths and frame sizes
  localparam logic [1:0] SOP_WL_12 = 2'h0;
  localparam logic [1:0] SOP_WL_16 = 2'h1;
  localparam int SOP_SAMPLE_W = 24;
  localparam int SOP_FRAME_W = 48;
  localparam logic [5:0] SOP_FB_12 = 6'h18;
  localparam logic [5:0] SOP_FB_16 = 6'h20;
  localparam logic [5:0] SOP_FB_24 = 6'h30;

  // Divisor range for the generated serial clock
  localparam logic [1:0] SOP_DIV_MIN = 2'h1;
  localparam logic [1:0] SOP_DIV_MAX = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Controller register map
  localparam int SOP_H_ADDR_W = 4;
  localparam logic [3:0] SOP_H_CTRL_ADDR = 4'h0;
  localparam logic [3:0] SOP_H_STAT_ADDR = 4'h4;
  localparam logic [3:0] SOP_H_RXI_ADDR = 4'h8;
  localparam logic [3:0] SOP_H_RXQ_ADDR = 4'hC;
  localparam logic [5:0] SOP_H_CTRL_RST = 6'h00;
  localparam int SOP_HC_CLK = 0;
  localparam int SOP_HC_AUTO = 1;
  localparam int SOP_HC_WL_LSB = 2;
  localparam int SOP_HC_WL_MSB = 3;
  localparam int SOP_HC_DIV_LSB = 4;
  localparam int SOP_HC_DIV_MSB = 5;
  localparam int SOP_HS_DONE = 0;
  localparam int SOP_HS_READY = 1;

  typedef enum logic [1:0] {
    SOP_IDLE = 2'b01,
    SOP_SHIFT = 2'b10
  } sop_state_t;

  function automatic logic [5:0] sop_frame_bits(input logic [1:0] wl);
    if (wl == SOP_WL_12) return SOP_FB_12;
    else if (wl == SOP_WL_16) return SOP_FB_16;
    else return SOP_FB_24;
  endfunction

  function automatic logic [1:0] sop_clamp_div(input logic [3:0] d);
    if (d == 4'h0) return SOP_DIV_MIN;
    else if (d > {2'h0, SOP_DIV_MAX}) return SOP_DIV_MAX;
    else return d[1:0];
  endfunction

endpackage

// [rtl/sop_port.sv]
// Serial output port of one channel: master or cascaded slave, with control registers
//
// What this block does
// R01 - Slave mode: controller supplies clock and sync
// R02 - Data-ready shows a sample waiting
// R03 - Controller raises sync one clock early
// R04 - Slave samples sync on clock rise
// R05 - Shift starts next rise, runs full frame
// R06 - Frame-end high during last Q bit
// R07 - Master drives clock, sync; slave listens
// R08 - Port 0 role from pin at reset
// R09 - Ports 1 to 3 reset as slaves
// R10 - Control bit 4 selects master role, ports 1 to 3
// R11 - Serial clock is reference over divisor+1
// R12 - Divisor from control bits, port 0 pins
// R13 - Slave clock may be slow, capped rate
// R14 - Controller clock fast enough per frame
// R15 - Data line released when not shifting
// R16 - Upstream frame-end feeds downstream sync
// R17 - Cascaded frame follows with no gap
// R18 - Frame is I then Q word
// R19 - Words go out most significant first
// R20 - Sync ignored while frame in progress
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/1ps
module sop_port
  import sop_pkg::*;
#(
  parameter bit IS_PORT0 = 1'b0 // Port 0 takes role and divisor from pins
) (
  input wire logic ref_clk, // Reference clock, 10 MHz
  input wire logic sys_rst, // Synchronous reset, high
  sop_link_if.device link, // Serial link
  input wire logic [SOP_ADDR_W-1:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [3:0] avs_byteenable, // Byte lanes
  input wire logic [31:0] avs_writedata, // Write data
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  input wire logic [SOP_SAMPLE_W-1:0] sampleI, // I sample
  input wire logic [SOP_SAMPLE_W-1:0] sampleQ, // Q sample
  input wire logic sampleValid, // Sample strobe
  input wire logic port0MasterSelectPin, // Port 0 role strap
  input wire logic [3:0] port0DivisorPin // Port 0 divisor strap
);
  import sop_pkg::*;

  typedef struct packed {
    sop_state_t state;
    logic [SOP_CTRL_W-1:0] ctrl;
    logic port0Master;
    logic [SOP_FRAME_W-1:0] shift;
    logic [5:0] bitsLeft;
    logic [SOP_SAMPLE_W-1:0] bufI;
    logic [SOP_SAMPLE_W-1:0] bufQ;
    logic bufFull;
    logic sclkPrev;
    logic fsyncOut;
    logic frameEnd;
    logic serialBit;
    logic drive;
    logic ack;
    logic [31:0] rdata;
  } sop_port_state_t;

  sop_port_state_t s_reg;
  sop_port_state_t s_next;
  logic isMaster;
  logic [1:0] divisor;
  logic genSclk;
  logic rise;
  logic startFrame;
  logic [1:0] wordLen;

  ////////////////////////////////////////////////////////////////////////////
  // Role and clock source

  assign isMaster = IS_PORT0 ? s_reg.port0Master : s_reg.ctrl[SOP_MASTER_BIT]; // R10
  assign divisor = sop_clamp_div(IS_PORT0 ? port0DivisorPin
                                          : s_reg.ctrl[SOP_DIV_MSB:SOP_DIV_LSB]); // R12
  assign wordLen = s_reg.ctrl[SOP_WL_MSB:SOP_WL_LSB];

  sop_clk_div u_clk_div (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .run(isMaster),
    .divisor(divisor),
    .sclk(genSclk)
  ); // R11

  // Edge taken from the line so master and slave time alike
  assign rise = link.sclk && !s_reg.sclkPrev; // R04
  // Sync with nothing buffered is ignored rather than sending stale data
  assign startFrame = rise && link.frameSync && s_reg.bufFull; // R04 R16

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_next = s_reg;
    s_next.sclkPrev = link.sclk;

    unique case (s_reg.state)
      SOP_IDLE: begin
        if (startFrame) begin
          s_next.state = SOP_SHIFT;
        end else if (rise && isMaster && s_reg.bufFull) begin
          s_next.fsyncOut = 1'b1; // R07
        end
      end
      SOP_SHIFT: begin
        if (rise) begin
          if (s_reg.bitsLeft == 6'h01) begin
            s_next.state = startFrame ? SOP_SHIFT : SOP_IDLE; // R17
            s_next.frameEnd = 1'b0;
            s_next.drive = 1'b0; // R15
          end else begin
            s_next.shift = {s_reg.shift[SOP_FRAME_W-2:0], 1'b0}; // R19
            s_next.serialBit = s_reg.shift[SOP_FRAME_W-2];
            s_next.bitsLeft = s_reg.bitsLeft - 6'h01; // R05 R20
            s_next.frameEnd = (s_reg.bitsLeft == 6'h02); // R06
          end
        end
      end
    endcase

    // Load the frame on the same edge that samples sync
    if (startFrame && (s_reg.state == SOP_IDLE || s_reg.bitsLeft == 6'h01)) begin
      s_next.state = SOP_SHIFT;
      s_next.shift = sop_pack_frame(wordLen, s_reg.bufI, s_reg.bufQ); // R18
      s_next.serialBit = s_next.shift[SOP_FRAME_W-1]; // R19
      s_next.bitsLeft = sop_frame_bits(wordLen); // R05
      s_next.drive = 1'b1; // R15
      s_next.frameEnd = 1'b0;
      s_next.fsyncOut = 1'b0;
      s_next.bufFull = 1'b0;
    end

    // New sample wins over the buffer being emptied
    if (sampleValid) begin
      s_next.bufI = sampleI;
      s_next.bufQ = sampleQ;
      s_next.bufFull = 1'b1; // R02
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register slave: one stall cycle, then answer

    s_next.ack = (avs_read || avs_write) && !s_reg.ack;
    if (avs_read && !s_reg.ack) begin
      if (avs_address == SOP_CTRL_ADDR) begin
        s_next.rdata = {22'h000000, s_reg.ctrl};
      end else if (avs_address == SOP_STAT_ADDR) begin
        s_next.rdata = 32'h00000000;
        s_next.rdata[SOP_ST_READY] = s_reg.bufFull;
        s_next.rdata[SOP_ST_BUSY] = (s_reg.state == SOP_SHIFT);
        s_next.rdata[SOP_ST_MASTER] = isMaster;
      end else begin
        s_next.rdata = 32'h00000000;
      end
    end
    if (avs_write && s_reg.ack && avs_address == SOP_CTRL_ADDR) begin
      if (avs_byteenable[0]) begin
        s_next.ctrl[7:0] = avs_writedata[7:0]; // R10 R12
      end
      if (avs_byteenable[1]) begin
        s_next.ctrl[9:8] = avs_writedata[9:8];
      end
    end
  end

  function automatic logic [SOP_FRAME_W-1:0] sop_pack_frame(
    input logic [1:0] wl,
    input logic [SOP_SAMPLE_W-1:0] i,
    input logic [SOP_SAMPLE_W-1:0] q
  );
    // Words take the top bits of each sample, left aligned in the shifter
    if (wl == SOP_WL_12) return {i[23:12], q[23:12], 24'h000000};
    else if (wl == SOP_WL_16) return {i[23:8], q[23:8], 16'h0000};
    else return {i, q};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s_reg <= '0;
      s_reg.state <= SOP_IDLE;
      s_reg.ctrl <= SOP_CTRL_RST; // R09
      // Strap is held in the role flop while reset lasts
      s_reg.port0Master <= port0MasterSelectPin; // R08
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign link.sclkDev = genSclk;
  assign link.sclkDevOen = !isMaster; // R07 R01
  assign link.fsyncDev = s_reg.fsyncOut;
  assign link.fsyncDevOen = !isMaster; // R07 R01
  assign link.serialOutDev = s_reg.serialBit;
  assign link.serialOutOen = !s_reg.drive; // R15
  assign link.frameEnd = s_reg.frameEnd; // R06
  assign link.dataReady = s_reg.bufFull; // R02
  assign avs_readdata = s_reg.rdata;
  assign avs_waitrequest = (avs_read || avs_write) && !s_reg.ack;
endmodule // sop_port

// [sim/sop_assertions.sv]
// Link checker: frame start, bit timing, frame end and master clock rate
`timescale 1ns/1ps
module sop_assertions (
  input wire logic ref_clk, // Reference clock
  input wire logic sys_rst, // Synchronous reset, high
  input wire logic sclkDev, // Device clock drive
  input wire logic sclkDevOen, // Device clock enable, low drives
  input wire logic fsyncDevOen, // Device sync enable, low drives
  input wire logic serialOutDev, // Device data bit
  input wire logic serialOutOen, // Data enable, low drives
  input wire logic frameEnd, // Last bit marker
  input wire logic dataReady, // Sample waiting
  input wire logic sclk, // Resolved serial clock
  input wire logic frameSync // Resolved frame sync
);
  logic sclkQ;
  logic startQ;
  logic rise;
  logic startNow;

  // Edge detect kept in flops so no sampled-value call sits in logic
  assign rise = sclk && !sclkQ;
  assign startNow = rise && frameSync && dataReady && serialOutOen;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sclkQ <= 1'h0;
      startQ <= 1'h0;
    end else begin
      sclkQ <= sclk;
      startQ <= rise && frameSync && dataReady;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////////////////////
  sequence s_start;
    startNow;
  endsequence
  sequence s_last;
    rise && frameEnd && !(frameSync && dataReady);
  endsequence
  sequence s_mclk;
    !sclkDevOen && $rose(sclkDev);
  endsequence
  sequence s_hold;
    !serialOutOen && !rise;
  endsequence
  sequence s_mid_sync;
    !serialOutOen && rise && frameSync && !frameEnd;
  endsequence

  a_shift_start: assert property (s_start |=> !serialOutOen)
    else $error("shift did not start after sync");
  a_idle_hold: assert property (serialOutOen && !startNow |=> serialOutOen)
    else $error("data driven without a sampled sync");
  a_frame_close: assert property (s_last |=> serialOutOen && !frameEnd)
    else $error("line not released after last bit");
  a_bit_stands: assert property (s_hold |=> serialOutOen || $stable(serialOutDev))
    else $error("data bit changed between clock rises");
  a_end_in_frame: assert property (frameEnd |-> !serialOutOen)
    else $error("frame end outside a frame");
  a_role_pair: assert property (sclkDevOen == fsyncDevOen)
    else $error("clock and sync roles differ");
  a_mclk_rate: assert property (s_mclk |=> !sclkDev ##[1:3] (sclkDev || sclkDevOen))
    else $error("master clock period out of range");
  a_ready_taken: assert property ($fell(dataReady) |-> startQ)
    else $error("ready dropped without a frame start");
  a_sync_ignored: assert property (s_mid_sync |=> !serialOutOen)
    else $error("sync in mid frame broke the frame");
endmodule // sop_assertions

// [sim/tb.sv]
// Self-checking bench: port and controller joined over the serial link
`timescale 1ns/1ps
module tb;
  import sop_pkg::*;
  logic ref_clk = 1'h0;
  logic sys_rst = 1'h1;
  logic [11:0] pAddr = 12'h000;
  logic [3:0] dAddr = 4'h0;
  logic pRd = 1'h0, pWr = 1'h0, dRd = 1'h0, dWr = 1'h0, sampleValid = 1'h0, sclkQ = 1'h0;
  logic [31:0] pWd = 32'h0, dWd = 32'h0, pRdData, dRdData;
  logic pWait, dWait;
  logic [23:0] sampleI = 24'h0, sampleQ = 24'h0;
  logic [31:0] seed = 32'h00005F74;
  logic [31:0] expq[$];
  logic [47:0] frq[$];
  logic [47:0] cap = 48'h0;
  int mismatches = 0, nChecks = 0, gap = 0, nb = 0, mdiv = 1, fbits = 0, n0 = 0;
  logic strap0 = 1'h1;
  logic [3:0] div0 = 4'h2;

  sop_link_if lk();
  sop_port #(.IS_PORT0(1'h0)) u_sop_port (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(lk),
    .avs_address(pAddr), .avs_read(pRd), .avs_write(pWr), .avs_byteenable(4'hF),
    .avs_writedata(pWd), .avs_readdata(pRdData), .avs_waitrequest(pWait),
    .sampleI(sampleI), .sampleQ(sampleQ), .sampleValid(sampleValid),
    .port0MasterSelectPin(1'h0), .port0DivisorPin(4'h0));
  sop_dsp u_sop_dsp (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(lk), .avs_address(dAddr),
    .avs_read(dRd), .avs_write(dWr), .avs_byteenable(4'hF), .avs_writedata(dWd),
    .avs_readdata(dRdData), .avs_waitrequest(dWait));
  // Second port strapped as port 0 master; its role and divisor come from pins only
  sop_link_if lk0();
  sop_port #(.IS_PORT0(1'h1)) u_sop_port0 (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(lk0),
    .avs_address(12'h000), .avs_read(1'h0), .avs_write(1'h0), .avs_byteenable(4'h0),
    .avs_writedata(32'h0), .avs_readdata(), .avs_waitrequest(), .sampleI(24'h0),
    .sampleQ(24'h0), .sampleValid(1'h0), .port0MasterSelectPin(strap0),
    .port0DivisorPin(div0));
  // No controller on this link: its side stays released
  assign lk0.sclkHostOen = 1'h1;
  assign lk0.fsyncHostOen = 1'h1;
  assign lk0.sclkHost = 1'h0;
  assign lk0.fsyncHost = 1'h0;
  sop_assertions u_sop_assertions (.ref_clk(ref_clk), .sys_rst(sys_rst), .sclkDev(lk.sclkDev),
    .sclkDevOen(lk.sclkDevOen), .fsyncDevOen(lk.fsyncDevOen), .serialOutDev(lk.serialOutDev),
    .serialOutOen(lk.serialOutOen), .frameEnd(lk.frameEnd), .dataReady(lk.dataReady),
    .sclk(lk.sclk), .frameSync(lk.frameSync));

  always #50 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic int wl(input int k);
    return k == 0 ? 12 : (k == 1 ? 16 : 24);
  endfunction

  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    nChecks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", nChecks, mismatches);
    if (mismatches == 0 && nChecks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // h selects the controller bus; request held until waitrequest is seen low
  task automatic bus(input bit h, input bit wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    if (h) begin
      dRd <= !wr;
      dWr <= wr;
      dAddr <= a[3:0];
      dWd <= d;
    end else begin
      pRd <= !wr;
      pWr <= wr;
      pAddr <= a;
      pWd <= d;
    end
    @(posedge ref_clk);
    while ((h ? dWait : pWait) !== 1'h0) @(posedge ref_clk);
    if (h) begin
      dRd <= 1'h0;
      dWr <= 1'h0;
    end else begin
      pRd <= 1'h0;
      pWr <= 1'h0;
    end
  endtask

  task automatic rd(input bit h, input logic [11:0] a, input logic [31:0] e);
    expq.push_back(e);
    bus(h, 1'h0, a, 32'h0);
  endtask

  task automatic send(input int w, output logic [23:0] i, output logic [23:0] q);
    logic [31:0] r;
    r = rnd();
    i = r[23:0];
    r = rnd();
    q = r[23:0];
    frq.push_back((48'(i >> (24 - w)) << w) | 48'(q >> (24 - w)));
    fbits = 2 * w;
    @(posedge ref_clk);
    sampleI <= i;
    sampleQ <= q;
    sampleValid <= 1'h1;
    @(posedge ref_clk);
    sampleValid <= 1'h0;
  endtask

  task automatic waitFrame();
    wait (lk.frameEnd === 1'h1);
    wait (lk.frameEnd === 1'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk) begin
    if (pRd && pWait === 1'h0) chk(48'(pRdData), 48'(expq.pop_front()));
    if (dRd && dWait === 1'h0) chk(48'(dRdData), 48'(expq.pop_front()));
  end

  // Wire watcher: bits taken at the rise that ends each bit
  always @(posedge ref_clk) begin
    gap = gap + 1;
    if (lk.sclk === 1'h1 && sclkQ === 1'h0 && !sys_rst) begin
      if (lk.sclkDevOen === 1'h0 && lk.serialOutOen === 1'h0) chk(48'(gap), 48'(mdiv + 1));
      gap = 0;
      if (lk.serialOutOen === 1'h0) begin
        cap = {cap[46:0], lk.serialOut};
        nb = nb + 1;
        if (lk.frameEnd === 1'h1) begin
          chk(48'(nb), 48'(fbits));
          chk(cap & ((48'h1 << fbits) - 48'h1), frq.pop_front());
          nb = 0;
        end
      end
    end
    sclkQ = lk.sclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [23:0] i;
    logic [23:0] q;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'h0;
    repeat (2) @(posedge ref_clk);
    // Divisor pin 2 gives one high cycle in every three
    repeat (12) begin
      @(posedge ref_clk);
      if (lk0.sclk === 1'h1) n0 = n0 + 1;
    end
    chk(48'(lk0.sclkDevOen), 48'h0);
    chk(48'(lk.sclkDevOen), 48'h1);
    chk(48'(n0), 48'h4);
    rd(1'h0, SOP_CTRL_ADDR, 32'h0);
    rd(1'h0, SOP_STAT_ADDR, 32'h0);
    rd(1'h0, 12'h000, 32'h0);
    for (int k = 0; k < 3; k++) begin
      bus(1'h0, 1'h1, SOP_CTRL_ADDR, 32'(k) << SOP_WL_LSB);
      send(wl(k), i, q);
      rd(1'h0, SOP_STAT_ADDR, 32'h1);
      bus(1'h1, 1'h1, SOP_H_CTRL_ADDR, 32'(((k + 1) << SOP_HC_DIV_LSB) | (k << SOP_HC_WL_LSB) | 3));
      waitFrame();
      rd(1'h1, SOP_H_STAT_ADDR, 32'h1);
      rd(1'h1, SOP_H_RXI_ADDR, 32'(i & ~((24'h1 << (24 - wl(k))) - 24'h1)));
      rd(1'h1, SOP_H_RXQ_ADDR, 32'(q & ~((24'h1 << (24 - wl(k))) - 24'h1)));
      bus(1'h1, 1'h1, SOP_H_STAT_ADDR, 32'h1);
      bus(1'h1, 1'h1, SOP_H_CTRL_ADDR, 32'h0);
    end
    // Host set for 12-bit words on a 24-bit port: its next sync lands mid frame
    send(24, i, q);
    bus(1'h1, 1'h1, SOP_H_CTRL_ADDR, 32'h13);
    wait (lk.serialOutOen === 1'h0);
    rd(1'h0, SOP_STAT_ADDR, 32'h2);
    send(24, i, q);
    rd(1'h0, SOP_STAT_ADDR, 32'h3);
    waitFrame();
    waitFrame();
    rd(1'h1, SOP_H_RXI_ADDR, 32'({i[23:12], 12'h000}));
    rd(1'h1, SOP_H_RXQ_ADDR, 32'({i[11:0], 12'h000}));
    bus(1'h1, 1'h1, SOP_H_STAT_ADDR, 32'h1);
    bus(1'h1, 1'h1, SOP_H_CTRL_ADDR, 32'h0);
    // Master with 24-bit words, each divisor in turn
    for (int d = 1; d < 4; d++) begin
      mdiv = d;
      bus(1'h0, 1'h1, SOP_CTRL_ADDR, 32'h50 | 32'(d));
      rd(1'h0, SOP_STAT_ADDR, 32'h4);
      send(24, i, q);
      waitFrame();
    end
    rd(1'h0, SOP_CTRL_ADDR, 32'h53);
    @(posedge ref_clk);
    test_done();
  end

  // Whole run is well under two thousand cycles; this limit only trips on a hang
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    test_done();
  end
endmodule // tb
